// ---- rtl/event_frame_tx.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R01] frame order: preamble, signature, payload, crc, delimiter
// [R02] preamble zero to five bytes, reset two 0xAA
// [R03] six-character signature follows the preamble
// [R04] thirty-byte payload of five fields
// [R05] timestamp digits hhmmssyymmdd from own clock
// [R06] event code as two ascii digits
// [R07] sample events carry four-digit alcohol reading
// [R08] no reading gives four ascii zeros
// [R09] key serial, or six ascii zeros
// [R10] crc-16 over payload bytes only
// [R11] zero init, reflected, high byte first default
// [R12] delimiter zero to five bytes, reset 0x0A 0x0D
// [R13] handshake can be switched off
// [R14] receiver acknowledges every frame
// [R15] ack ends the frame for good
// [R16] receiver sends nak on reception error
// [R17] nak resends the frame at once
// [R18] resends per frame are bounded
// [R19] timeout resends, then discards at limit
// [R20] timeout and retry count are configurable
// [R21] queue holds three pending events
// [R22] queued events wait for current handshake
// [R23] 8N1 serial, no flow control, 56000 default
module event_frame_tx
   import txf_pkg::*;
#(
   parameter int         TIMEOUT_CYC = txf_pkg::RESP_TIMEOUT_CYC,
   parameter logic [3:0] RETRY_DEF   = txf_pkg::RETRY_RESET
) (
   // clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_RESET,
   // apb slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // event source
   input  wire logic        I_EVT_STROBE,
   input  wire logic [7:0]  I_EVT_CODE,
   input  wire logic [15:0] I_EVT_ALC,
   input  wire logic        I_EVT_HAS_ALC,
   input  wire logic        I_KEY_PRESENT,
   input  wire logic [47:0] I_KEY_SERIAL,
   input  wire logic [47:0] I_TIME,
   input  wire logic [47:0] I_UNIT_SERIAL,
   output logic             O_QUEUE_FULL,
   // serial link
   input  wire logic        I_RXD,
   output logic             O_TXD
);
   // configuration and counters
   logic [1:0]   ctrl;
   logic [31:0]  pre_lo, del_lo, timeout;
   logic [10:0]  pre_hi, del_hi;
   logic [15:0]  baud;
   logic [3:0]   retry;
   logic         overflow;
   logic [7:0]   delivered, discarded;
   // frame engine
   frame_state_t state, next_state;
   logic [4:0]   idx;
   logic [15:0]  crc;
   logic [EV_W-1:0] cur;
   logic [3:0]   tries, lim;
   logic         ack_cur, lsb_cur;
   logic [2:0]   pre_n, del_n;
   logic [31:0]  timer;
   // queue
   logic [EV_W-1:0] q [QUEUE_DEPTH];
   logic [1:0]   qcnt;

   function automatic logic [2:0] clamp5(input logic [2:0] n);
      return (n > FIX_MAX) ? FIX_MAX : n;
   endfunction : clamp5

   function automatic logic [7:0] fix_byte(input logic [31:0] lo, input logic [10:0] hi, input logic [4:0] i);
      return (i == 5'h04) ? hi[7:0] : lo[8*i[1:0] +: 8];
   endfunction : fix_byte

   // apb decode; zero wait states, so the access phase always completes
   wire wr_en   = I_PSEL && I_PENABLE && I_PWRITE;
   wire addr_ok = (I_PADDR[1:0] == 2'h0) && (I_PADDR <= OFS_STATUS);
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

   wire [31:0] status = {8'h00, discarded, delivered, 3'h0, overflow, 1'b0, qcnt, state != ST_IDLE};
   wire [31:0] rd_mux =
      (I_PADDR == OFS_CTRL)    ? {30'h0, ctrl} :
      (I_PADDR == OFS_PRE_LO)  ? pre_lo :
      (I_PADDR == OFS_PRE_HI)  ? {21'h0, pre_hi} :
      (I_PADDR == OFS_DEL_LO)  ? del_lo :
      (I_PADDR == OFS_DEL_HI)  ? {21'h0, del_hi} :
      (I_PADDR == OFS_BAUD)    ? {16'h0, baud} :
      (I_PADDR == OFS_TIMEOUT) ? timeout :
      (I_PADDR == OFS_RETRY)   ? {28'h0, retry} :
      (I_PADDR == OFS_STATUS)  ? status : 32'h0;

   // read data is captured in the setup phase so it leaves a flop
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) O_PRDATA <= 32'h0;
      else if (I_PSEL && !I_PENABLE && !I_PWRITE) O_PRDATA <= rd_mux;
   end

   // configuration registers
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         ctrl    <= CTRL_RESET;
         pre_lo  <= PRE_LO_RESET; // R02
         pre_hi  <= HI_RESET;
         del_lo  <= DEL_LO_RESET; // R12
         del_hi  <= HI_RESET;
         baud    <= BAUD_DIV_RESET; // R23
         timeout <= 32'(TIMEOUT_CYC); // R20
         retry   <= RETRY_DEF;
      end else if (wr_en) begin
         if (I_PADDR == OFS_CTRL)    ctrl    <= I_PWDATA[1:0];
         if (I_PADDR == OFS_PRE_LO)  pre_lo  <= I_PWDATA;
         if (I_PADDR == OFS_PRE_HI)  pre_hi  <= I_PWDATA[10:0];
         if (I_PADDR == OFS_DEL_LO)  del_lo  <= I_PWDATA;
         if (I_PADDR == OFS_DEL_HI)  del_hi  <= I_PWDATA[10:0];
         if (I_PADDR == OFS_BAUD)    baud    <= I_PWDATA[15:0];
         if (I_PADDR == OFS_TIMEOUT) timeout <= I_PWDATA;
         if (I_PADDR == OFS_RETRY)   retry   <= I_PWDATA[3:0];
      end
   end

   // event queue; a new event is only popped once the engine is idle
   wire             pop    = (state == ST_IDLE) && (qcnt != 2'h0); // R22
   wire             q_full = (qcnt == 2'(QUEUE_DEPTH));
   wire             push   = I_EVT_STROBE && (!q_full || pop); // R21
   wire [1:0]       wr_idx = qcnt - {1'b0, pop};
   wire [EV_W-1:0]  new_ev = {I_TIME, I_EVT_CODE, I_EVT_ALC, I_EVT_HAS_ALC, I_KEY_PRESENT, I_KEY_SERIAL}; // R05 R09
   assign O_QUEUE_FULL = q_full;

   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         for (int i = 0; i < QUEUE_DEPTH; i++) q[i] <= '0;
         qcnt <= 2'h0;
      end else begin
         for (int i = 0; i < QUEUE_DEPTH; i++) begin
            if (push && wr_idx == 2'(i)) q[i] <= new_ev;
            else if (pop) q[i] <= q[(i + 1) % QUEUE_DEPTH];
         end
         qcnt <= qcnt + {1'b0, push} - {1'b0, pop};
      end
   end

   // overflow is sticky, write one to clear; a new loss wins over the clear
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) overflow <= 1'b0;
      else overflow <= (I_EVT_STROBE && !push) ||
                       (overflow && !(wr_en && I_PADDR == OFS_STATUS && I_PWDATA[ST_OVF]));
   end

   // payload image of the current event
   wire [47:0]  alc_code = {24'h0, cur[EV_CODE +: 8], cur[EV_HAS] ? cur[EV_ALC +: 16] : 16'h0}; // R07 R08
   wire [95:0]  time_a   = bcd_ascii(cur[EV_TIME +: 48]); // R05
   wire [95:0]  ac_a     = bcd_ascii(alc_code); // R06
   wire [47:0]  key_a    = cur[EV_KEY] ? cur[47:0] : {6{ASCII_ZERO}}; // R09
   wire [239:0] payload  = {I_UNIT_SERIAL, time_a, ac_a[47:0], key_a}; // R04

   // byte selection per section
   wire [7:0] pre_b = fix_byte(pre_lo, pre_hi, idx);
   wire [7:0] del_b = fix_byte(del_lo, del_hi, idx);
   wire [7:0] sig_b = SIGNATURE[8*(SIG_LEN - 5'h01 - idx) +: 8]; // R03
   wire [7:0] pay_b = payload[8*(PAY_LEN - 5'h01 - idx) +: 8];
   wire [7:0] crc_b = ((idx == 5'h00) ^ lsb_cur) ? crc[15:8] : crc[7:0]; // R11
   wire       tx_valid = (state != ST_IDLE) && (state != ST_WAIT);
   wire       tx_ready;
   wire [7:0] tx_data =
      (state == ST_PRE) ? pre_b :
      (state == ST_SIG) ? sig_b :
      (state == ST_PAY) ? pay_b :
      (state == ST_CRC) ? crc_b : del_b;
   wire [4:0] sec_len =
      (state == ST_PRE) ? {2'h0, pre_n} :
      (state == ST_SIG) ? SIG_LEN :
      (state == ST_PAY) ? PAY_LEN :
      (state == ST_CRC) ? CRC_LEN : {2'h0, del_n};
   wire       take = tx_valid && tx_ready;
   wire       last = take && (idx == sec_len - 5'h01);

   // reply decode
   wire       rx_valid;
   wire [7:0] rx_data;
   wire       got_ack  = (state == ST_WAIT) && rx_valid && (rx_data == ACK_CHAR); // R14
   wire       got_nak  = (state == ST_WAIT) && rx_valid && (rx_data == NAK_CHAR); // R16
   wire       timed_out = (state == ST_WAIT) && (timer >= timeout);
   wire       again    = (got_nak || (timed_out && !got_ack)) && (tries < lim);
   wire       give_up  = (got_nak || (timed_out && !got_ack)) && (tries >= lim);
   wire       restart  = pop || again;
   frame_state_t first_st, end_st;
   assign first_st = (pop ? clamp5(pre_hi[HI_CNT_LSB +: 3]) : pre_n) != 3'h0 ? ST_PRE : ST_SIG; // R02
   assign end_st   = ack_cur ? ST_WAIT : ST_IDLE; // R13

   // section sequencing
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (pop) next_state = first_st;
         ST_PRE:  if (last) next_state = ST_SIG; // R01
         ST_SIG:  if (last) next_state = ST_PAY;
         ST_PAY:  if (last) next_state = ST_CRC;
         ST_CRC:  if (last) next_state = (del_n != 3'h0) ? ST_DEL : end_st; // R12
         ST_DEL:  if (last) next_state = end_st;
         ST_WAIT: begin
            if (got_ack) next_state = ST_IDLE; // R15
            else if (again) next_state = first_st; // R17 R19
            else if (give_up) next_state = ST_IDLE; // R18
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) state <= ST_IDLE;
      else state <= next_state;
   end

   // index, crc and timer; crc restarts on every resend
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         idx   <= 5'h00;
         crc   <= CRC_INIT;
         timer <= 32'h0;
      end else begin
         idx   <= (restart || last) ? 5'h00 : (take ? idx + 5'h01 : idx);
         timer <= (state == ST_WAIT) ? timer + 32'h1 : 32'h0;
         if (restart) crc <= CRC_INIT;
         else if (take && state == ST_PAY) crc <= crc_byte(crc, pay_b); // R10
      end
   end

   // frame context is latched at pop so writes to ctrl, retry and the byte counts cannot tear a frame; byte values and baud are read live
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         cur     <= '0;
         tries   <= 4'h0;
         lim     <= 4'h0;
         ack_cur <= 1'b0;
         lsb_cur <= 1'b0;
         pre_n   <= 3'h0;
         del_n   <= 3'h0;
      end else if (pop) begin
         cur     <= q[0];
         tries   <= 4'h0;
         lim     <= retry; // R20
         ack_cur <= ctrl[CTRL_ACK_EN];
         lsb_cur <= ctrl[CTRL_CRC_LSB];
         pre_n   <= clamp5(pre_hi[HI_CNT_LSB +: 3]);
         del_n   <= clamp5(del_hi[HI_CNT_LSB +: 3]);
      end else if (again) begin
         tries <= tries + 4'h1; // R18
      end
   end

   // outcome counters, wrapping
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         delivered <= 8'h00;
         discarded <= 8'h00;
      end else begin
         delivered <= delivered + {7'h0, got_ack}; // R15
         discarded <= discarded + {7'h0, give_up && !got_ack};
      end
   end

   serial_tx u_tx (
      .i_clk   (I_CLK),
      .i_reset (I_RESET),
      .i_div   (baud),
      .i_valid (tx_valid),
      .i_data  (tx_data),
      .o_ready (tx_ready),
      .o_txd   (O_TXD)
   );

   serial_rx u_rx (
      .i_clk   (I_CLK),
      .i_reset (I_RESET),
      .i_rxd   (I_RXD),
      .i_div   (baud),
      .o_valid (rx_valid),
      .o_data  (rx_data)
   );

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   chk_pre_to_sig: assert property (state == ST_PRE && last |=> state == ST_SIG) // R01
      else $error("preamble not followed by signature");
   chk_payload_len: assert property (state == ST_PAY && take && idx == 5'h1D |=> state == ST_CRC) // R04
      else $error("payload length wrong");
   chk_alc_zero: assert property (state == ST_PAY && !cur[EV_HAS] && idx >= 5'h14 && idx <= 5'h17
                                  |-> pay_b == ASCII_ZERO) // R08
      else $error("alcohol field not zero");
   chk_crc_order: assert property (state == ST_CRC && idx == 5'h00 && !lsb_cur |-> tx_data == crc[15:8]) // R11
      else $error("crc high byte not first");
   chk_simplex_no_wait: assert property (!ack_cur |-> state != ST_WAIT) // R13
      else $error("waiting with handshake off");
   chk_ack_done: assert property (got_ack |=> state == ST_IDLE ##1 !(state inside {ST_PAY, ST_CRC, ST_DEL, ST_WAIT})) // R15
      else $error("frame continued after ack");
   chk_nak_resend: assert property (got_nak && tries < lim |=> state inside {ST_PRE, ST_SIG} && idx == 5'h00) // R17
      else $error("nak did not resend at once");
   chk_retry_bound: assert property (state != ST_IDLE |-> tries <= lim) // R18
      else $error("retries past limit");
   chk_timeout_discard: assert property (timed_out && !got_ack && tries == lim |=> state == ST_IDLE) // R19
      else $error("frame not discarded at limit");
   chk_queue_bound: assert property (I_EVT_STROBE && q_full && !pop |=> $stable(qcnt) && overflow) // R21
      else $error("queue bound broken");
   chk_hold_queue: assert property (state != ST_IDLE && qcnt != 2'h0 |=> $past(qcnt) <= qcnt) // R22
      else $error("event left queue early");

   cov_ack: cover property (got_ack);
   cov_nak: cover property (got_nak ##1 state inside {ST_PRE, ST_SIG});
   cov_discard: cover property (give_up);
   cov_overflow: cover property (I_EVT_STROBE && q_full && !pop);
endmodule : event_frame_tx
`default_nettype wire

// ---- shared/txf_pkg.sv ----
`default_nettype none
package txf_pkg;
   // clock and serial timing
   localparam int          CLK_HZ           = 200_000_000;
   localparam int          BAUD_DEFAULT     = 56000;
   localparam logic [15:0] BAUD_DIV_RESET   = 16'(CLK_HZ / BAUD_DEFAULT);
   localparam int          RESP_TIMEOUT_MS  = 10;
   localparam int          RESP_TIMEOUT_CYC = CLK_HZ / 1000 * RESP_TIMEOUT_MS;
   localparam logic [3:0]  RETRY_RESET      = 4'h3;
   localparam logic [3:0]  UART_FRAME_BITS  = 4'hA;
   localparam logic [3:0]  UART_STOP_SLOT   = 4'h9;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_PRE_LO  = 8'h04;
   localparam logic [7:0]  OFS_PRE_HI  = 8'h08;
   localparam logic [7:0]  OFS_DEL_LO  = 8'h0C;
   localparam logic [7:0]  OFS_DEL_HI  = 8'h10;
   localparam logic [7:0]  OFS_BAUD    = 8'h14;
   localparam logic [7:0]  OFS_TIMEOUT = 8'h18;
   localparam logic [7:0]  OFS_RETRY   = 8'h1C;
   localparam logic [7:0]  OFS_STATUS  = 8'h20;
   // fields and reset values
   localparam int          CTRL_ACK_EN  = 0;
   localparam int          CTRL_CRC_LSB = 1;
   localparam int          HI_CNT_LSB   = 8;
   localparam int          ST_OVF       = 4;
   localparam logic [1:0]  CTRL_RESET   = 2'h1;
   localparam logic [31:0] PRE_LO_RESET = 32'h0000_AAAA;
   localparam logic [31:0] DEL_LO_RESET = 32'h0000_0D0A;
   localparam logic [10:0] HI_RESET     = 11'h200;
   localparam logic [2:0]  FIX_MAX      = 3'h5;
   // frame content
   localparam logic [47:0] SIGNATURE  = 48'h4556_5453_5243; // arbitrary neutral value
   localparam logic [7:0]  ACK_CHAR   = 8'h06;
   localparam logic [7:0]  NAK_CHAR   = 8'h15;
   localparam logic [3:0]  ASCII_HI   = 4'h3;
   localparam logic [7:0]  ASCII_ZERO = 8'h30;
   localparam logic [15:0] CRC_POLY   = 16'hA001;
   localparam logic [15:0] CRC_INIT   = 16'h0000;
   localparam logic [4:0]  SIG_LEN    = 5'h06;
   localparam logic [4:0]  PAY_LEN    = 5'h1E;
   localparam logic [4:0]  CRC_LEN    = 5'h02;
   localparam int          QUEUE_DEPTH = 3;
   // queued event: time bcd, code bcd, alcohol bcd, alcohol flag, key flag, key serial
   localparam int EV_W = 122;
   localparam int EV_TIME = 74;
   localparam int EV_CODE = 66;
   localparam int EV_ALC  = 50;
   localparam int EV_HAS  = 49;
   localparam int EV_KEY  = 48;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01, ST_PRE = 7'h02, ST_SIG = 7'h04, ST_PAY = 7'h08,
      ST_CRC  = 7'h10, ST_DEL = 7'h20, ST_WAIT = 7'h40
   } frame_state_t;

   // reflected crc, one byte, lsb first
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      return r;
   endfunction : crc_byte

   // twelve bcd digits to twelve ascii characters
   function automatic logic [95:0] bcd_ascii(input logic [47:0] b);
      logic [95:0] a;
      for (int i = 0; i < 12; i++) a[8*i +: 8] = {ASCII_HI, b[4*i +: 4]};
      return a;
   endfunction : bcd_ascii
endpackage : txf_pkg
`default_nettype wire

// ---- rtl/serial_tx.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_tx
   import txf_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   // byte stream in
   input  wire logic [15:0] i_div,
   input  wire logic        i_valid,
   input  wire logic [7:0]  i_data,
   output logic             o_ready,
   // line
   output logic             o_txd
);
   logic [9:0]  shift;
   logic [3:0]  bits;
   logic [15:0] cnt;

   assign o_ready = (bits == 4'h0);
   assign o_txd   = shift[0];

   // start bit, eight data bits lsb first, one stop bit; idle shifts in ones
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         shift <= 10'h3FF;
         bits  <= 4'h0;
         cnt   <= 16'h0000;
      end else if (bits == 4'h0) begin
         if (i_valid) begin
            shift <= {1'b1, i_data, 1'b0}; // R23
            bits  <= UART_FRAME_BITS;
            cnt   <= i_div - 16'h0001;
         end
      end else if (cnt == 16'h0000) begin
         shift <= {1'b1, shift[9:1]};
         bits  <= bits - 4'h1;
         cnt   <= i_div - 16'h0001;
      end else begin
         cnt <= cnt - 16'h0001;
      end
   end
endmodule : serial_tx
`default_nettype wire

// ---- rtl/serial_rx.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_rx
   import txf_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   // line and rate
   input  wire logic        i_rxd,
   input  wire logic [15:0] i_div,
   // received byte
   output logic             o_valid,
   output logic [7:0]       o_data
);
   logic        s1, s2, s3, line;
   logic        busy;
   logic [3:0]  bitn;
   logic [15:0] cnt;

   // three-stage sync; a level counts once the last two agree
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         {s1, s2, s3, line} <= 4'hF;
      end else begin
         s1   <= i_rxd;
         s2   <= s1;
         s3   <= s2;
         line <= (s2 == s3) ? s3 : line;
      end
   end

   // sample mid-bit; a framing error drops the byte
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         busy    <= 1'b0;
         bitn    <= 4'h0;
         cnt     <= 16'h0000;
         o_valid <= 1'b0;
         o_data  <= 8'h00;
      end else begin
         o_valid <= 1'b0;
         if (!busy) begin
            busy <= !line;
            bitn <= 4'h0;
            cnt  <= i_div >> 1;
         end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
         end else begin
            cnt  <= i_div - 16'h0001;
            bitn <= bitn + 4'h1;
            if (bitn == 4'h0 && line) busy <= 1'b0; // glitch, not a start
            else if (bitn == UART_STOP_SLOT) begin
               busy    <= 1'b0;
               o_valid <= line; // R23
            end else if (bitn != 4'h0) o_data <= {line, o_data[7:1]};
         end
      end
   end
endmodule : serial_rx
`default_nettype wire

// ---- bench/link_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
module link_partner (
   // clock and bit rate
   input  wire logic        i_clk,
   input  wire logic [15:0] i_div,
   // serial line
   input  wire logic        i_txd,
   output logic             o_rxd
);
   logic [7:0] got[$];
   logic [7:0] b;
   int         bad_stop;
   // the reply line rests at the mark level between characters
   initial begin
      o_rxd    = 1'b1;
      bad_stop = 0;
   end
   // sample mid-cell, lsb first; a low stop cell is a framing fault
   always begin
      @(negedge i_txd);
      repeat (i_div / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (i_div) @(posedge i_clk);
         b[i] = i_txd;
      end
      repeat (i_div) @(posedge i_clk);
      if (i_txd !== 1'b1) bad_stop++;
      got.push_back(b);
   end
   // one reply character: start, eight data, stop
   task automatic send(input logic [7:0] c);
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk);
         o_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i - 1];
         repeat (i_div - 1) @(posedge i_clk);
      end
   endtask : send
endmodule : link_partner
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import txf_pkg::*;
   typedef logic [7:0] bq_t[$];
   typedef struct {logic [7:0] code; logic [15:0] alc; logic has; logic kp; logic [47:0] key; logic [47:0] tm;} ev_t;
   // a short bit cell keeps each frame near 3400 cycles
   localparam logic [15:0] DIV = 16'h0008;
   logic        clk, reset, psel, penable, pwrite, strobe, has_alc, key_on, rxd, txd, pready, pslverr, qfull;
   logic [7:0]  paddr, code;
   logic [15:0] alc;
   logic [31:0] pwdata, prdata, rdata;
   logic [47:0] key, tstamp, unit;
   logic [7:0]  pre[5], del[5];
   logic        rerr, lsb;
   int          err_count, checks, cycles, npre, ndel, v;
   ev_t         expq[$];
   logic [7:0]  ofs[10] = '{OFS_CTRL, OFS_PRE_LO, OFS_PRE_HI, OFS_DEL_LO, OFS_DEL_HI, OFS_BAUD, OFS_TIMEOUT,
                            OFS_RETRY, 8'h24, 8'h02};
   logic [31:0] rst[10] = '{32'h1, 32'hAAAA, 32'h200, 32'h0D0A, 32'h200, 32'hDF3, 32'h7D0, 32'h3, 32'h0, 32'h0};

   event_frame_tx #(.TIMEOUT_CYC(2000), .RETRY_DEF(4'h3)) dut_u (.I_CLK(clk), .I_RESET(reset), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EVT_STROBE(strobe), .I_EVT_CODE(code), .I_EVT_ALC(alc),
      .I_EVT_HAS_ALC(has_alc), .I_KEY_PRESENT(key_on), .I_KEY_SERIAL(key), .I_TIME(tstamp),
      .I_UNIT_SERIAL(unit), .O_QUEUE_FULL(qfull), .I_RXD(rxd), .O_TXD(txd));
   link_partner part_u (.i_clk(clk), .i_div(DIV), .i_txd(txd), .o_rxd(rxd));

   always #2.5 clk = ~clk;
   // watchdog sized for nine frames plus the reply waits
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic status(input logic [31:0] exp);
      apb(1'b0, OFS_STATUS, 32'h0);
      check({8'h00, rdata[23:0]}, exp);
   endtask : status
   function automatic logic [47:0] rnd_bcd();
      logic [47:0] r;
      for (int i = 0; i < 12; i++) r[4*i +: 4] = 4'($urandom_range(0, 9));
      return r;
   endfunction : rnd_bcd
   // expected frame from the event and the bench's copy of the settings
   function automatic bq_t frame(input ev_t e);
      bq_t         p, f;
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 5; i >= 0; i--) p.push_back(unit[8*i +: 8]);
      for (int i = 11; i >= 0; i--) p.push_back({4'h3, e.tm[4*i +: 4]});
      for (int i = 1; i >= 0; i--) p.push_back({4'h3, e.code[4*i +: 4]});
      for (int i = 3; i >= 0; i--) p.push_back(e.has ? {4'h3, e.alc[4*i +: 4]} : 8'h30);
      for (int i = 5; i >= 0; i--) p.push_back(e.kp ? e.key[8*i +: 8] : 8'h30);
      foreach (p[i]) begin
         c ^= {8'h00, p[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      for (int i = 0; i < npre; i++) f.push_back(pre[i]);
      for (int i = 5; i >= 0; i--) f.push_back(SIGNATURE[8*i +: 8]);
      f = {f, p};
      for (int i = 0; i < 2; i++) f.push_back((lsb ^ (i == 1)) ? c[7:0] : c[15:8]);
      for (int i = 0; i < ndel; i++) f.push_back(del[i]);
      return f;
   endfunction : frame
   // raises the strobe with fresh fields; the caller drops it
   task automatic fire(input int c);
      ev_t x;
      x.code = {4'(c / 10), 4'(c % 10)};
      x.tm   = rnd_bcd();
      x.key  = rnd_bcd();
      x.alc  = x.key[15:0];
      x.key  = {16'($urandom), $urandom};
      x.has  = 1'($urandom);
      x.kp   = 1'($urandom);
      @(posedge clk);
      strobe  <= 1'b1;
      code    <= x.code;
      alc     <= x.alc;
      has_alc <= x.has;
      key_on  <= x.kp;
      key     <= x.key;
      tstamp  <= x.tm;
      expq.push_back(x);
   endtask : fire
   // first byte must show within lo..hi cycles, then the frame is compared whole
   task automatic take(input bit keep, input int lo, input int hi);
      bq_t f;
      int  k;
      f = frame(expq[0]);
      k = 0;
      while (part_u.got.size() == 0) begin
         @(posedge clk);
         k++;
      end
      check(32'(k >= lo && k <= hi), 32'h1);
      while (part_u.got.size() < f.size()) @(posedge clk);
      foreach (f[i]) check({24'h0, part_u.got.pop_front()}, {24'h0, f[i]});
      if (!keep) void'(expq.pop_front());
   endtask : take
   task automatic drop_and_idle(input int n);
      @(posedge clk);
      strobe <= 1'b0;
      if (n > 0) take(1'b0, 0, 20000);
   endtask : drop_and_idle

   initial begin
      {clk, psel, penable, pwrite, strobe, has_alc, key_on, paddr, code, alc, key, tstamp, pwdata} = '0;
      reset = 1'b1;
      v = $urandom(15);
      unit = {16'($urandom), $urandom};
      pre = '{8'hAA, 8'hAA, 8'h00, 8'h00, 8'h00};
      del = '{8'h0A, 8'h0D, 8'h00, 8'h00, 8'h00};
      npre = 2;
      ndel = 2;
      lsb = 1'b0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      foreach (ofs[i]) begin
         apb(1'b0, ofs[i], 32'h0);
         check(rdata, rst[i]);
         check({31'h0, rerr}, {31'h0, i > 7});
      end
      apb(1'b1, OFS_BAUD, 32'(DIV));
      apb(1'b1, OFS_RETRY, 32'h1);
      $display("register test done");
      fire(1);
      drop_and_idle(1);
      part_u.send(ACK_CHAR);
      repeat (3000) @(posedge clk);
      check(32'(part_u.got.size()), 32'h0);
      status(32'h0000_0100);
      $display("ack test done");
      fire(32);
      drop_and_idle(0);
      take(1'b1, 0, 20000);
      part_u.send(NAK_CHAR);
      take(1'b0, 0, 500);
      part_u.send(NAK_CHAR);
      repeat (3000) @(posedge clk);
      check(32'(part_u.got.size()), 32'h0);
      status(32'h0001_0100);
      $display("nak test done");
      fire($urandom_range(2, 31));
      drop_and_idle(0);
      take(1'b1, 0, 20000);
      take(1'b0, 1500, 2300);
      repeat (3000) @(posedge clk);
      check(32'(part_u.got.size()), 32'h0);
      status(32'h0002_0100);
      $display("timeout test done");
      v = $urandom;
      apb(1'b1, OFS_CTRL, 32'h2);
      apb(1'b1, OFS_PRE_HI, 32'h0);
      apb(1'b1, OFS_DEL_LO, 32'(v));
      apb(1'b1, OFS_DEL_HI, {21'h0, 3'h5, 8'(v)});
      for (int i = 0; i < 5; i++) del[i] = 8'(v >> (8 * (i % 4)));
      {npre, ndel, lsb} = {32'd0, 32'd5, 1'b1};
      for (int i = 0; i < 5; i++) fire($urandom_range(1, 32));
      drop_and_idle(0);
      @(posedge clk);
      check({31'h0, qfull}, 32'h1);
      status(32'h0002_0117);
      apb(1'b1, OFS_STATUS, 32'h10);
      status(32'h0002_0107);
      void'(expq.pop_back());
      repeat (4) take(1'b0, 0, 20000);
      status(32'h0002_0100);
      check(32'(part_u.bad_stop), 32'h0);
      $display("queue test done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
